/* verilog/pps_pkg.sv */
// Package for the programming-port pin sharing block
package pps_pkg;

  // Default length of the serial shift register
  localparam int SHIFT_LEN_DEF = 16;
  // Reset value of the shift register
  localparam logic SHIFT_RST_BIT = 1'h0;
  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;
  // Synchroniser reset levels {enable, global reset, in0, in1, in3, in5, clock zero}
  // Both active-low pins read as idle high, so reset never fakes a mode entry or a clear
  localparam logic [6:0] SYNC_RST_VAL = 7'h60;
  // Reset value of logic-block and I/O registers
  localparam logic REG_RST_BIT = 1'h0;

  // Four shared pins as seen in normal operation
  typedef struct packed {
    logic in0;   // serial_prog_in pin
    logic in1;   // control-select pin
    logic in3;   // serial_prog_out pin
    logic in5;   // shift clock pin
  } pps_pins_s;

  // Programming-side controls handed to the state machine
  typedef struct packed {
    logic active;
    logic ctl_data;
    logic ctl_sel;
    logic shift_en;
  } pps_prog_s;

endpackage : pps_pkg

/* verilog/pps_sync.sv */
// Two-flip-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
module pps_sync #(
  parameter int               WIDTH   = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage only feeds the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Registers; reset to the pins' idle levels so no false edge follows reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : pps_sync

/* verilog/pps_top.sv */
// Pin sharing between dedicated inputs and the programming port
`timescale 1ns/100ps
module pps_top #(
  parameter int SHIFT_LEN = pps_pkg::SHIFT_LEN_DEF,
  parameter int NUM_REGS  = 8
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // Programming enable and global reset pins
  input  wire logic                      prog_enable_n,
  input  wire logic                      global_reset_n,
  // Shared pins
  input  wire logic                      pin_in0,
  input  wire logic                      pin_in1,
  input  wire logic                      pin_in3_i,
  output logic                           pin_in3_o,
  output logic                           pin_in3_oe,
  input  wire logic                      pin_in5,
  // First dedicated clock pin
  input  wire logic                      global_clock_zero,
  // Dedicated inputs to the logic array
  output pps_pkg::pps_pins_s             array_inputs,
  // Programming controls to the state machine
  output pps_pkg::pps_prog_s             prog_ctl,
  // Shift register view
  output logic [SHIFT_LEN-1:0]           shift_data,
  // Logic-block and I/O registers (model of cleared state)
  input  wire logic [NUM_REGS-1:0]       reg_load_data,
  input  wire logic                      reg_load,
  output logic [NUM_REGS-1:0]            lb_regs,
  output logic [NUM_REGS-1:0]            io_regs,
  // Clock tree taps: one per logic block
  output logic [NUM_REGS-1:0]            lb_clk_tap
);

  localparam int NSYNC = 7;

  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  logic             en_n_s;
  logic             grst_n_s;
  logic             in0_s;
  logic             in1_s;
  logic             in3_s;
  logic             in5_s;
  logic             y0_s;

  // Every pin passes two flip-flops before use
  assign raw = {prog_enable_n, global_reset_n, pin_in0, pin_in1, pin_in3_i, pin_in5, global_clock_zero};

  // Enable and global reset start high: a zero would enter programming mode or clear the registers after reset
  pps_sync #(
    .WIDTH   (NSYNC),
    .RST_VAL (pps_pkg::SYNC_RST_VAL)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (raw),
    .sync_out (syn)
  );

  assign {en_n_s, grst_n_s, in0_s, in1_s, in3_s, in5_s, y0_s} = syn;

  // State registers
  logic                  prog_q;
  logic                  prog_d;
  logic                  sclk_q;
  logic                  sclk_d;
  logic [SHIFT_LEN-1:0]  shreg_q;
  logic [SHIFT_LEN-1:0]  shreg_d;
  logic                  sdo_q;
  logic                  sdo_d;
  logic                  oe_q;
  logic                  oe_d;
  pps_pkg::pps_pins_s    arr_q;
  pps_pkg::pps_pins_s    arr_d;
  pps_pkg::pps_prog_s    ctl_q;
  pps_pkg::pps_prog_s    ctl_d;
  logic                  rise;

  // Shift clock edge found by sampling; only valid while pin toggles slowly versus core_clk
  assign rise = prog_q && in5_s && !sclk_q;

  // Mode, shift path and pin direction
  always_comb begin
    prog_d  = !en_n_s;
    sclk_d  = in5_s;
    shreg_d = shreg_q;
    sdo_d   = sdo_q;
    oe_d    = !en_n_s;
    arr_d   = arr_q;
    ctl_d   = '0;
    if (prog_q) begin
      ctl_d.active   = 1'h1;
      ctl_d.ctl_data = in0_s;
      ctl_d.ctl_sel  = in1_s;
      ctl_d.shift_en = rise;
      if (rise) begin
        shreg_d = {shreg_q[SHIFT_LEN-2:0], in0_s};
        sdo_d   = shreg_q[SHIFT_LEN-2];
      end
    end else begin
      // Array sees all four shared pins as plain inputs
      arr_d.in0 = in0_s;
      arr_d.in1 = in1_s;
      arr_d.in3 = in3_s;
      arr_d.in5 = in5_s;
      sdo_d     = shreg_q[SHIFT_LEN-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prog_q  <= 1'h0;
      sclk_q  <= 1'h0;
      shreg_q <= {SHIFT_LEN{pps_pkg::SHIFT_RST_BIT}};
      sdo_q   <= 1'h0;
      oe_q    <= 1'h0;
      arr_q   <= '0;
      ctl_q   <= '0;
    end else begin
      prog_q  <= prog_d;
      sclk_q  <= sclk_d;
      shreg_q <= shreg_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
      arr_q   <= arr_d;
      ctl_q   <= ctl_d;
    end
  end

  // Logic-block and I/O registers, cleared by the global reset pin
  logic [NUM_REGS-1:0] lb_q;
  logic [NUM_REGS-1:0] lb_d;
  logic [NUM_REGS-1:0] io_q;
  logic [NUM_REGS-1:0] io_d;
  logic [NUM_REGS-1:0] tap_q;
  logic [NUM_REGS-1:0] tap_d;

  always_comb begin
    lb_d  = lb_q;
    io_d  = io_q;
    tap_d = {NUM_REGS{y0_s}};
    if (!grst_n_s) begin
      lb_d = {NUM_REGS{pps_pkg::REG_RST_BIT}};
      io_d = {NUM_REGS{pps_pkg::REG_RST_BIT}};
    end else if (reg_load) begin
      lb_d = reg_load_data;
      io_d = reg_load_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lb_q  <= '0;
      io_q  <= '0;
      tap_q <= '0;
    end else begin
      lb_q  <= lb_d;
      io_q  <= io_d;
      tap_q <= tap_d;
    end
  end

  // Outputs straight from flip-flops
  assign pin_in3_o    = sdo_q;
  assign pin_in3_oe   = oe_q;
  assign array_inputs = arr_q;
  assign prog_ctl     = ctl_q;
  assign shift_data   = shreg_q;
  assign lb_regs      = lb_q;
  assign io_regs      = io_q;
  assign lb_clk_tap   = tap_q;

endmodule : pps_top

/* sim/pps_prog_model.sv */
// Programmer model: drives the shared pins and samples the serial output
`timescale 1ns/100ps
module pps_prog_model (
  // Pins toward the device
  input  wire logic core_clk,
  input  wire logic serial_prog_out,
  output logic      en_n, serial_prog_in, sel, sclk
);
  initial begin
    en_n = 1'h1;
    serial_prog_in  = 1'h0;
    sel  = 1'h0;
    sclk = 1'h0;
  end
  // One 176 ns shift clock; clock still between bits
  task automatic shift_bit(input logic b, output logic seen);
    serial_prog_in <= b;
    repeat (10) @(posedge core_clk);
    seen = serial_prog_out;
    sclk <= 1'h1;
    repeat (10) @(posedge core_clk);
    sclk <= 1'h0;
    @(posedge core_clk);
    serial_prog_in  <= ~b; // Hold over: show the inverse, not the old bit
    @(posedge core_clk);
  endtask : shift_bit
endmodule : pps_prog_model

/* sim/pps_top_properties.sv */
// Port assertions for the pin sharing block
`timescale 1ns/100ps
module pps_top_properties #(parameter int SHIFT_LEN = 16, parameter int NUM_REGS = 8) (
  // Clock, reset and pins
  input wire logic core_clk, rst_n, prog_enable_n, global_reset_n, global_clock_zero,
  input wire logic pin_in0, pin_in1, pin_in3_i, pin_in5, pin_in3_o, pin_in3_oe,
  // Block outputs
  input wire pps_pkg::pps_pins_s array_inputs,
  input wire pps_pkg::pps_prog_s prog_ctl,
  input wire logic [SHIFT_LEN-1:0] shift_data,
  input wire logic [NUM_REGS-1:0] lb_regs, io_regs, lb_clk_tap
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Controls are decoded from the registered mode, one cycle after the pin direction
  a_mode_enter: assert property ($fell(prog_enable_n) |-> ##3 pin_in3_oe
    ##1 (pin_in3_oe && prog_ctl.active)) else $error("mode not entered");
  a_mode_leave: assert property ($rose(prog_enable_n) |-> ##3 !pin_in3_oe
    ##1 (!pin_in3_oe && !prog_ctl.active)) else $error("mode not left");
  a_idle_quiet: assert property (!prog_ctl.active |-> prog_ctl == '0)
    else $error("controls active outside mode");
  a_array_pass: assert property ((prog_enable_n && $stable({pin_in0, pin_in1, pin_in3_i, pin_in5}))[*6]
    |-> array_inputs == {pin_in0, pin_in1, pin_in3_i, pin_in5}) else $error("array input wrong");
  a_ctl_follow: assert property ((!prog_enable_n && $stable({pin_in0, pin_in1}))[*6]
    |-> prog_ctl.ctl_data == pin_in0 && prog_ctl.ctl_sel == pin_in1) else $error("control wrong");
  a_shift_pulse: assert property (prog_ctl.shift_en |=> !prog_ctl.shift_en)
    else $error("shift pulse too long");
  a_shift_in: assert property (prog_ctl.shift_en |-> shift_data[0] == $past(pin_in0, 4)
    && shift_data[SHIFT_LEN-1:1] == $past(shift_data[SHIFT_LEN-2:0])) else $error("shift wrong");
  a_shift_hold: assert property (!prog_ctl.shift_en |-> $stable(shift_data))
    else $error("shift without clock");
  a_out_msb: assert property (pin_in3_oe |-> pin_in3_o == shift_data[SHIFT_LEN-1])
    else $error("serial out wrong");
  a_greset_clr: assert property ((!global_reset_n)[*4] |-> lb_regs == '0 && io_regs == '0)
    else $error("registers not cleared");
  a_clk_tap: assert property ($stable(global_clock_zero)[*4] |-> lb_clk_tap == {NUM_REGS{global_clock_zero}})
    else $error("clock tap wrong");
endmodule : pps_top_properties
bind pps_top pps_top_properties #(.SHIFT_LEN(SHIFT_LEN), .NUM_REGS(NUM_REGS)) u_props (.core_clk, .rst_n,
  .prog_enable_n, .global_reset_n, .global_clock_zero, .pin_in0, .pin_in1, .pin_in3_i, .pin_in5, .pin_in3_o,
  .pin_in3_oe, .array_inputs, .prog_ctl, .shift_data, .lb_regs, .io_regs, .lb_clk_tap);

/* sim/test_pps_top.sv */
// Self-checking bench for the pin sharing block
`timescale 1ns/100ps
module test_pps_top;
  logic               core_clk, rst_n, grst_n, p3_i, gclk0, rload, p3_o, p3_oe, en_n, serial_prog_in, sel, sclk, seen;
  logic [7:0]         rdata, lb, io, tap;
  logic [15:0]        sd, pat;
  pps_pkg::pps_pins_s ai;
  pps_pkg::pps_prog_s pc;
  int                 num_errors, n_tests;
  // Rows: upper nibble drives {in0,in1,in3,in5}, lower nibble expected
  logic [7:0]         rows [4] = '{8'h00, 8'hAA, 8'h55, 8'h99};
  pps_prog_model m (.core_clk(core_clk), .serial_prog_out(p3_o), .en_n(en_n), .serial_prog_in(serial_prog_in), .sel(sel), .sclk(sclk));
  pps_top #(.SHIFT_LEN(16), .NUM_REGS(8)) DUT (.core_clk(core_clk), .rst_n(rst_n), .prog_enable_n(en_n),
    .global_reset_n(grst_n), .pin_in0(serial_prog_in), .pin_in1(sel), .pin_in3_i(p3_i), .pin_in3_o(p3_o),
    .pin_in3_oe(p3_oe), .pin_in5(sclk), .global_clock_zero(gclk0), .array_inputs(ai), .prog_ctl(pc),
    .shift_data(sd), .reg_load_data(rdata), .reg_load(rload), .lb_regs(lb), .io_regs(io), .lb_clk_tap(tap));
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Watchdog: a hang counts as a mismatch
  initial begin
    #500000;
    num_errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'h0; grst_n = 1'h1; p3_i = 1'h0; gclk0 = 1'h0; rload = 1'h0; rdata = '0;
    num_errors = 0; n_tests = 0; pat = 16'hB38D;
    repeat (12) @(posedge core_clk);
    check("oe in reset", p3_oe, 16'h0);
    rst_n <= 1'h1;
    rload <= 1'h1;
    repeat (2) @(posedge core_clk);
    check("oe after reset", p3_oe, 16'h0);
    foreach (rows[i]) begin
      {m.serial_prog_in, m.sel, p3_i, m.sclk} <= rows[i][7:4];
      gclk0 <= rows[i][7];
      rdata <= rows[i];
      repeat (6) @(posedge core_clk);
      check("array inputs", ai, rows[i][3:0]);
      check("controls", pc, 16'h0);
      check("clock taps", tap, {8{rows[i][3]}});
      check("lb load", lb, rows[i]);
      check("io load", io, rows[i]);
    end
    // Clear must win over a load held high
    grst_n <= 1'h0;
    repeat (5) @(posedge core_clk);
    check("lb clear", lb, 16'h0);
    check("io clear", io, 16'h0);
    grst_n <= 1'h1;
    m.en_n <= 1'h0;
    m.sel  <= 1'h1;
    m.sclk <= 1'h0; // Last row left the shift clock high; first bit needs a rising edge
    repeat (6) @(posedge core_clk);
    check("oe on", p3_oe, 16'h1);
    check("ctl sel", pc.ctl_sel, 16'h1);
    check("ctl active", pc.active, 16'h1);
    check("ctl data", pc.ctl_data, 16'h1);
    // Second pass shifts the inverse and reads the first pattern back
    for (int j = 0; j < 32; j++) begin
      m.shift_bit(pat[15 - j % 16] ^ (j > 15), seen);
      check("serial out", seen, (j > 15) ? pat[31 - j] : 1'h0);
      if (j == 15) check("shift reg", sd, pat);
    end
    m.en_n <= 1'h1;
    repeat (6) @(posedge core_clk);
    check("oe off", p3_oe, 16'h0);
    m.shift_bit(1'h1, seen);
    check("shift idle", sd, ~pat);
    rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    check("shift reset", sd, 16'h0);
    print_verdict();
  end
endmodule : test_pps_top
